// *** common/uart_shadow_defines.svh ***
// offsets, field positions, reset values and counts of the shadow bank
// assumes 8-bit byte addresses on a 32-bit classic Wishbone bus
`ifndef UART_SHADOW_DEFINES_SVH
`define UART_SHADOW_DEFINES_SVH

// register byte offsets
`define RX_LEVEL_OFFSET       8'h84
`define SOFT_RESET_OFFSET     8'h88
`define RTS_MIRROR_OFFSET     8'h8c
`define BREAK_MIRROR_OFFSET   8'h90
`define DMA_MODE_OFFSET       8'h94
`define FIFO_EN_OFFSET        8'h98

// field positions
`define SOFT_RESET_TX_BIT     2
`define SOFT_RESET_RX_BIT     1
`define SOFT_RESET_ALL_BIT    0
`define MIRROR_BIT            0

// fifo geometry: level field is address width plus one bits
`define FIFO_ADDR_WIDTH       4

// reset values
`define MIRROR_RESET          1'h0
`define DATA_RESET            32'h0000_0000

// hold counts in sys_clk cycles; the infrared pulse period is IR_PULSE_PERIOD plus one
`define FIFO_RESET_HOLD       3'h3
`define UART_RESET_HOLD       3'h4
`define IR_PULSE_PERIOD       4'hf

`endif

// *** common/uart_shadow_pkg.sv ***
// types shared by the shadow register bank
// assumes the defines header sits on the include path
package uart_shadow_pkg;
  `include "uart_shadow_defines.svh"

  // decoded register selection
  typedef enum logic [2:0] {
    SEL_NONE, SEL_RX_LEVEL, SEL_SOFT_RESET, SEL_RTS, SEL_BREAK, SEL_DMA_MODE, SEL_FIFO_EN
  } reg_sel_e;

  // classic wishbone request from the master
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_s;

  // writes of the main control registers by the rest of the uart
  typedef struct packed {
    logic mcrWr;
    logic rtsBit;
    logic lcrWr;
    logic breakBit;
    logic fcrWr;
    logic fifoEnBit;
    logic rxResetBit;
    logic txResetBit;
    logic dmaModeBit;
  } main_wr_s;

  // modem control and fifo status seen by the bank
  typedef struct packed {
    logic                      autoFlow;
    logic                      altTrigger;
    logic                      loopback;
    logic                      irActive;
    logic                      txSerial;
    logic                      txEmpty;
    logic                      txAtTrigger;
    logic                      rxAboveTrigger;
    logic                      rxAlmostFull;
    logic [`FIFO_ADDR_WIDTH:0] rxLevel;
  } uart_status_s;

  // every flop of the bank
  typedef struct packed {
    logic        ack;
    logic [31:0] rdData;
    logic        rts;
    logic        brk;
    logic        dmaMode;
    logic        fifoEn;
    logic [2:0]  txRstCnt;
    logic [2:0]  rxRstCnt;
    logic [2:0]  urCnt;
    logic [3:0]  irCnt;
    logic        txFifoRst;
    logic        rxFifoRst;
    logic        uartRst;
    logic        rtsN;
    logic        serOut;
    logic        irOutN;
    logic        loopRts;
    logic        loopRxData;
    logic        dmaTxReqN;
    logic        dmaTxSingleN;
    logic        dmaRxReqN;
    logic        dmaRxSingleN;
  } bank_state_s;
endpackage : uart_shadow_pkg

// *** core/uart_shadow_register_bank.sv ***
// shadow register bank: rx level, software reset and four control mirrors
// assumes fifo status and main-register writes come from logic on sys_clk
// Operation
// - rx level register reads fifo entry count, upper bits zero
// - registers of an unconfigured option read as zero
// - bit 2 of software reset empties the transmit fifo
// - with the extra dma handshake option, transmit fifo reset drops dma transmit request and single
// - bit 1 of software reset empties the receive fifo
// - with the extra dma handshake option, receive fifo reset drops dma receive request and single
// - both fifo reset bits clear themselves
// - bit 0 resets the whole uart, released synchronously
// - whole reset also reaches the baud-side clock domain
// - rts mirror shares storage with the modem control rts bit
// - without auto flow, rts output is low when rts bit set
// - auto flow deasserts rts when receive fifo above trigger
// - alternative trigger deasserts rts with two slots left
// - loopback holds rts high and loops the rts bit back
// - break mirror holds serial output low outside loopback
// - break with infrared active pulses the infrared output
// - loopback feeds break back to the receiver internally
// - dma mode mirror selects signalling mode 0 or 1 when the extra dma handshake option is off
// - fifo enable mirror enables both fifos, updating one bit
// - clearing fifo enable resets both fifo controls
`timescale 1ns/1ps
module uart_shadow_register_bank
  import uart_shadow_pkg::*;
#(
  parameter bit HAS_FIFO      = 1'b1,
  parameter bit HAS_FIFO_STAT = 1'b1,
  parameter bit HAS_SHADOW    = 1'b1,
  parameter bit EXTRA_DMA_HANDSHAKE_OPTION     = 1'b0,
  parameter bit AUTO_FLOW     = 1'b1,
  parameter bit IR_MODE       = 1'b1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // wishbone slave
  input  wire wb_req_s      wbReq,
  output logic [31:0]       wbDatO,
  output logic              wbAck,
  // rest of the uart
  input  wire main_wr_s     mainWr,
  input  wire uart_status_s uartStat,
  // control mirrors toward the uart core
  output logic              rtsBit,
  output logic              breakBit,
  output logic              dmaModeBit,
  output logic              fifoEnBit,
  // fifo and uart resets
  output logic              txFifoRst,
  output logic              rxFifoRst,
  output logic              uartRst,
  // pins and loopback paths
  output logic              rtsN,
  output logic              serOut,
  output logic              irOutN,
  output logic              loopRts,
  output logic              loopRxData,
  // dma handshake
  output logic              dmaTxReqN,
  output logic              dmaTxSingleN,
  output logic              dmaRxReqN,
  output logic              dmaRxSingleN
);

  localparam bank_state_s RESET_STATE = '{
    rtsN: 1'b1, serOut: 1'b1, irOutN: 1'b1, loopRxData: 1'b1,
    dmaTxReqN: 1'b1, dmaTxSingleN: 1'b1, dmaRxReqN: 1'b1, dmaRxSingleN: 1'b1,
    rdData: `DATA_RESET, default: '0};

  bank_state_s stateR;
  bank_state_s stateNxt;

  // address decode, shared by the read and write paths
  function automatic reg_sel_e decodeReg(input logic [7:0] adr);
    unique case (adr)
      `RX_LEVEL_OFFSET:     decodeReg = SEL_RX_LEVEL;
      `SOFT_RESET_OFFSET:   decodeReg = SEL_SOFT_RESET;
      `RTS_MIRROR_OFFSET:   decodeReg = SEL_RTS;
      `BREAK_MIRROR_OFFSET: decodeReg = SEL_BREAK;
      `DMA_MODE_OFFSET:     decodeReg = SEL_DMA_MODE;
      `FIFO_EN_OFFSET:      decodeReg = SEL_FIFO_EN;
      default:              decodeReg = SEL_NONE;
    endcase
  endfunction : decodeReg

  logic     busReq;
  logic     busWr;
  reg_sel_e regSel;
  logic     txFlush;
  logic     rxFlush;
  logic     rtsActive;

  // next-state logic for the whole bank
  always_comb begin
    stateNxt = stateR;
    busReq   = wbReq.cyc & wbReq.stb & ~stateR.ack;
    busWr    = busReq & wbReq.we & wbReq.sel[0];
    regSel   = decodeReg(wbReq.adr);
    // one-cycle ack, data valid with it; unmapped reads give zero
    stateNxt.ack    = busReq;
    stateNxt.rdData = `DATA_RESET;
    if (busReq && !wbReq.we) begin
      unique case (regSel)
        // level read, zero when status absent
        SEL_RX_LEVEL: if (HAS_FIFO && HAS_FIFO_STAT) begin
          stateNxt.rdData[`FIFO_ADDR_WIDTH:0] = uartStat.rxLevel;
        end
        SEL_RTS:      stateNxt.rdData[`MIRROR_BIT] = HAS_SHADOW & stateR.rts;
        SEL_BREAK:    stateNxt.rdData[`MIRROR_BIT] = HAS_SHADOW & stateR.brk;
        SEL_DMA_MODE: stateNxt.rdData[`MIRROR_BIT] = HAS_SHADOW & HAS_FIFO & stateR.dmaMode;
        SEL_FIFO_EN:  stateNxt.rdData[`MIRROR_BIT] = HAS_SHADOW & HAS_FIFO & stateR.fifoEn;
        default:      stateNxt.rdData = `DATA_RESET; // write-only or unmapped
      endcase
    end

    // count down the fifo reset holds first, so any new request below reloads them
    if (stateR.txRstCnt != 3'h0) stateNxt.txRstCnt = stateR.txRstCnt - 3'h1;
    if (stateR.rxRstCnt != 3'h0) stateNxt.rxRstCnt = stateR.rxRstCnt - 3'h1;

    // main register writes land in the shared bits first
    if (mainWr.mcrWr) stateNxt.rts = mainWr.rtsBit;
    if (mainWr.lcrWr) stateNxt.brk = mainWr.breakBit;
    if (mainWr.fcrWr && HAS_FIFO) begin
      stateNxt.fifoEn  = mainWr.fifoEnBit;
      stateNxt.dmaMode = mainWr.dmaModeBit;
      if (mainWr.txResetBit) stateNxt.txRstCnt = `FIFO_RESET_HOLD;
      if (mainWr.rxResetBit) stateNxt.rxRstCnt = `FIFO_RESET_HOLD;
    end

    // bus writes come after main writes so they win a same-cycle clash with them
    if (busWr && HAS_SHADOW) begin
      unique case (regSel)
        SEL_SOFT_RESET: begin
          // fifo resets only when fifos exist
          if (HAS_FIFO && wbReq.dat[`SOFT_RESET_TX_BIT]) stateNxt.txRstCnt = `FIFO_RESET_HOLD;
          if (HAS_FIFO && wbReq.dat[`SOFT_RESET_RX_BIT]) stateNxt.rxRstCnt = `FIFO_RESET_HOLD;
          if (wbReq.dat[`SOFT_RESET_ALL_BIT]) stateNxt.urCnt = `UART_RESET_HOLD;
        end
        SEL_RTS:      stateNxt.rts = wbReq.dat[`MIRROR_BIT];
        SEL_BREAK:    stateNxt.brk = wbReq.dat[`MIRROR_BIT];
        SEL_DMA_MODE: if (HAS_FIFO) stateNxt.dmaMode = wbReq.dat[`MIRROR_BIT];
        SEL_FIFO_EN:  if (HAS_FIFO) stateNxt.fifoEn = wbReq.dat[`MIRROR_BIT];
        default:      stateNxt.urCnt = stateNxt.urCnt; // read-only or unmapped
      endcase
    end

    // enable falling resets both fifo controls
    if (stateR.fifoEn && !stateNxt.fifoEn) begin
      stateNxt.txRstCnt = `FIFO_RESET_HOLD;
      stateNxt.rxRstCnt = `FIFO_RESET_HOLD;
    end

    // reset pulses end by themselves after the hold
    txFlush = stateNxt.txRstCnt != 3'h0;
    rxFlush = stateNxt.rxRstCnt != 3'h0;
    stateNxt.txFifoRst = txFlush;
    stateNxt.rxFifoRst = rxFlush;

    // rts gated by auto flow threshold
    rtsActive = stateNxt.rts;
    if (AUTO_FLOW && uartStat.autoFlow && stateNxt.fifoEn) begin
      if (uartStat.altTrigger ? uartStat.rxAlmostFull : uartStat.rxAboveTrigger) begin
        rtsActive = 1'b0;
      end
    end
    // loopback: pin inactive, value turned back internally
    stateNxt.rtsN    = uartStat.loopback | ~rtsActive;
    stateNxt.loopRts = uartStat.loopback & stateNxt.rts;

    // break drives the line low or loops back
    stateNxt.serOut     = uartStat.loopback | (~stateNxt.brk & uartStat.txSerial);
    stateNxt.loopRxData = ~uartStat.loopback | (~stateNxt.brk & uartStat.txSerial);

    // infrared break: a short low pulse every period
    stateNxt.irOutN = 1'b1;
    stateNxt.irCnt  = 4'h0;
    if (IR_MODE && uartStat.irActive && stateNxt.brk && !uartStat.loopback) begin
      stateNxt.irCnt  = (stateR.irCnt == `IR_PULSE_PERIOD) ? 4'h0 : stateR.irCnt + 4'h1;
      stateNxt.irOutN = stateR.irCnt != 4'h0;
    end

    // mode 0 tracks single characters, mode 1 thresholds
    if (EXTRA_DMA_HANDSHAKE_OPTION) begin
      stateNxt.dmaTxReqN    = ~uartStat.txAtTrigger;
      stateNxt.dmaTxSingleN = uartStat.txEmpty ? 1'b0 : ~uartStat.txAtTrigger;
      stateNxt.dmaRxReqN    = ~uartStat.rxAboveTrigger;
      stateNxt.dmaRxSingleN = uartStat.rxLevel == '0;
    end else begin
      stateNxt.dmaTxReqN    = stateNxt.dmaMode ? ~uartStat.txAtTrigger : ~uartStat.txEmpty;
      stateNxt.dmaTxSingleN = 1'b1;
      stateNxt.dmaRxReqN    = stateNxt.dmaMode ? ~uartStat.rxAboveTrigger
                                               : (uartStat.rxLevel == '0);
      stateNxt.dmaRxSingleN = 1'b1;
    end
    // transmit flush silences transmit dma lines
    if (EXTRA_DMA_HANDSHAKE_OPTION && txFlush) begin
      stateNxt.dmaTxReqN    = 1'b1;
      stateNxt.dmaTxSingleN = 1'b1;
    end
    // receive flush silences receive dma lines
    if (EXTRA_DMA_HANDSHAKE_OPTION && rxFlush) begin
      stateNxt.dmaRxReqN    = 1'b1;
      stateNxt.dmaRxSingleN = 1'b1;
    end

    // whole reset: bank held at reset, pulse out to both domains
    if (stateR.urCnt != 3'h0) begin
      stateNxt         = RESET_STATE;
      stateNxt.urCnt   = stateR.urCnt - 3'h1;
    end
    stateNxt.uartRst = stateNxt.urCnt != 3'h0;
  end

  // single state register; synchronous reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateR <= RESET_STATE;
    end else begin
      stateR <= stateNxt;
    end
  end

  // outputs straight from the state flops
  assign wbAck        = stateR.ack;
  assign wbDatO       = stateR.rdData;
  assign rtsBit       = stateR.rts;
  assign breakBit     = stateR.brk;
  assign dmaModeBit   = stateR.dmaMode;
  assign fifoEnBit    = stateR.fifoEn;
  assign txFifoRst    = stateR.txFifoRst;
  assign rxFifoRst    = stateR.rxFifoRst;
  assign uartRst      = stateR.uartRst;
  assign rtsN         = stateR.rtsN;
  assign serOut       = stateR.serOut;
  assign irOutN       = stateR.irOutN;
  assign loopRts      = stateR.loopRts;
  assign loopRxData   = stateR.loopRxData;
  assign dmaTxReqN    = stateR.dmaTxReqN;
  assign dmaTxSingleN = stateR.dmaTxSingleN;
  assign dmaRxReqN    = stateR.dmaRxReqN;
  assign dmaRxSingleN = stateR.dmaRxSingleN;

  // checks on the bank's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence busWriteTo(logic [7:0] ofs, int bitPos);
    wbReq.cyc && wbReq.stb && wbReq.we && wbReq.sel[0] && !wbAck && !uartRst
      && wbReq.adr == ofs && wbReq.dat[bitPos] && !mainWr.fcrWr;
  endsequence

  sequence flushHeld(logic sig);
    sig [*3] ##1 !sig;
  endsequence

  ack_single_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");

  rx_level_read_a: assert property (wbReq.cyc && wbReq.stb && !wbReq.we && !wbAck
      && wbReq.adr == `RX_LEVEL_OFFSET && !uartRst && HAS_FIFO && HAS_FIFO_STAT
      |=> wbDatO[`FIFO_ADDR_WIDTH:0] == $past(uartStat.rxLevel)
          && wbDatO[31:`FIFO_ADDR_WIDTH+1] == '0)
    else $error("rx level readback wrong");

  tx_reset_self_a: assert property ((HAS_SHADOW && HAS_FIFO)
      and busWriteTo(`SOFT_RESET_OFFSET, `SOFT_RESET_TX_BIT)
      |=> flushHeld(txFifoRst))
    else $error("transmit fifo reset not a three cycle pulse");

  rx_reset_self_a: assert property ((HAS_SHADOW && HAS_FIFO)
      and busWriteTo(`SOFT_RESET_OFFSET, `SOFT_RESET_RX_BIT)
      |=> flushHeld(rxFifoRst))
    else $error("receive fifo reset not a three cycle pulse");

  tx_dma_quiet_a: assert property (EXTRA_DMA_HANDSHAKE_OPTION && txFifoRst |-> dmaTxReqN && dmaTxSingleN)
    else $error("transmit dma active during flush");

  rx_dma_quiet_a: assert property (EXTRA_DMA_HANDSHAKE_OPTION && rxFifoRst |-> dmaRxReqN && dmaRxSingleN)
    else $error("receive dma active during flush");

  uart_reset_pulse_a: assert property (HAS_SHADOW
      and busWriteTo(`SOFT_RESET_OFFSET, `SOFT_RESET_ALL_BIT)
      |=> uartRst [*4] ##1 !uartRst && !rtsBit && !breakBit && !fifoEnBit)
    else $error("whole uart reset hold wrong");

  rts_mirror_write_a: assert property (HAS_SHADOW and busWriteTo(`RTS_MIRROR_OFFSET, 0)
      |=> rtsBit)
    else $error("rts mirror write lost");

  loop_rts_high_a: assert property (uartStat.loopback |=> rtsN && loopRts == rtsBit)
    else $error("rts pin driven in loopback");

  // serOut follows loopback one cycle late, so look at the loopback it was built from
  break_line_low_a: assert property (breakBit && !$past(uartStat.loopback)
      && !$past(uartRst) |-> !serOut)
    else $error("serial output not held low on break");

  fifo_disable_flush_a: assert property (HAS_FIFO && fifoEnBit && !uartRst
      ##1 !fifoEnBit && !uartRst |-> txFifoRst && rxFifoRst)
    else $error("disabling fifos did not flush them");

endmodule : uart_shadow_register_bank

// *** verif/uart_core_model.sv ***
// behavioural rest of the uart: receive fifo occupancy and status levels
// assumes the bench supplies the static status bits and a push strobe
`timescale 1ns/1ps
module uart_core_model
  import uart_shadow_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // pushes and flushes
  input  wire logic         rxPush,
  input  wire logic         rxFifoRst,
  input  wire logic         uartRst,
  input  wire uart_status_s statIn,
  // status toward the bank
  output uart_status_s      statOut
);
  logic [`FIFO_ADDR_WIDTH:0] level_r;

  // flush empties fifo
  // flush wins over push so a reset never leaves a stale count
  always_ff @(posedge sys_clk) begin
    if (rst || rxFifoRst || uartRst) begin
      level_r <= '0;
    end else if (rxPush) begin
      level_r <= level_r + 5'h01;
    end
  end

  // thresholds follow occupancy, the rest passes through
  always_comb begin
    statOut                = statIn;
    statOut.rxLevel        = level_r;
    statOut.rxAboveTrigger = level_r > 5'h08;
    statOut.rxAlmostFull   = level_r >= 5'h0e;
  end
endmodule : uart_core_model

// *** verif/uart_shadow_register_bank_bench.sv ***
// self-checking bench of the shadow register bank, random mirror traffic
// assumes default parameters: fifos, status, shadows, infrared, auto flow on
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module uart_shadow_register_bank_bench;
  import uart_shadow_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, rxPush = 1'b0;
  wb_req_s      wbReq = '0;
  main_wr_s     mainWr = '0;
  uart_status_s statIn = '0, uartStat;
  logic [31:0]  wbDatO, q, d;
  logic wbAck, rtsBit, breakBit, dmaModeBit, fifoEnBit, txFifoRst, rxFifoRst, uartRst;
  logic rtsN, serOut, irOutN, loopRts, loopRxData, dmaTxReqN, dmaTxSingleN, dmaRxReqN, dmaRxSingleN;
  int numErrors = 0, checksDone = 0, cycles = 0, seed = 39, n, c;

  uart_shadow_register_bank dut_u (.sys_clk(sys_clk), .rst(rst), .wbReq(wbReq), .wbDatO(wbDatO),
    .wbAck(wbAck), .mainWr(mainWr), .uartStat(uartStat), .rtsBit(rtsBit), .breakBit(breakBit),
    .dmaModeBit(dmaModeBit), .fifoEnBit(fifoEnBit), .txFifoRst(txFifoRst), .rxFifoRst(rxFifoRst),
    .uartRst(uartRst), .rtsN(rtsN), .serOut(serOut), .irOutN(irOutN), .loopRts(loopRts),
    .loopRxData(loopRxData), .dmaTxReqN(dmaTxReqN), .dmaTxSingleN(dmaTxSingleN),
    .dmaRxReqN(dmaRxReqN), .dmaRxSingleN(dmaRxSingleN));
  uart_core_model model_u (.sys_clk(sys_clk), .rst(rst), .rxPush(rxPush), .rxFifoRst(rxFifoRst),
    .uartRst(uartRst), .statIn(statIn), .statOut(uartStat));

  // 10 MHz clock, bounded run
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      finishTest();
    end
  end

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finishTest

  // classic cycle: hold until ack sampled high, take data and release at that edge
  // no wait count of its own: only the bench timeout ends a hung request
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] dv,
                    output logic [31:0] r);
    @(posedge sys_clk);
    wbReq <= '{adr: a, dat: dv, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    r = wbDatO;
    wbReq <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic [31:0] r;
    wb(a, 1'b1, dv, r);
  endtask : wr

  task automatic settle(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : settle

  task automatic push(input int k);
    repeat (k) @(posedge sys_clk) rxPush <= 1'b1;
    @(posedge sys_clk) rxPush <= 1'b0;
  endtask : push

  // counts, over 20 cycles, high cycles of a reset pulse or low cycles of irOutN
  task automatic countHigh(input int which, output int cnt);
    cnt = 0;
    repeat (20) begin
      @(negedge sys_clk);
      case (which)
        0: cnt += txFifoRst;
        1: cnt += rxFifoRst;
        2: cnt += uartRst;
        default: cnt += !irOutN;
      endcase
    end
  endtask : countHigh

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // zero after reset, unmapped and write-only places read zero
    for (int i = 0; i < 7; i++) begin
      wb((i == 6) ? 8'h40 : 8'h84 + 8'(4 * i), 1'b0, 32'h0, q);
      `CHK(q, 32'h0)
    end
    $display("test reset done");
    // random mirror traffic, only bit 0 is stored
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      wr(`RTS_MIRROR_OFFSET + 8'(4 * (i % 4)), d);
      wb(`RTS_MIRROR_OFFSET + 8'(4 * (i % 4)), 1'b0, 32'h0, q);
      `CHK(q, {31'h0, d[0]})
    end
    $display("test mirrors done");
    // main register writes land in the shared bits
    @(posedge sys_clk) mainWr <= '{mcrWr: 1'b1, rtsBit: 1'b1, lcrWr: 1'b1, breakBit: 1'b1,
                                  default: 1'b0};
    @(posedge sys_clk) mainWr <= '0;
    wb(`RTS_MIRROR_OFFSET, 1'b0, 32'h0, q);
    `CHK(q, 32'h1)
    wb(`BREAK_MIRROR_OFFSET, 1'b0, 32'h0, q);
    `CHK(q, 32'h1)
    wr(`BREAK_MIRROR_OFFSET, 32'h0);
    $display("test main path done");
    // receive level and flow control
    n = 1 + ($unsigned($random(seed)) % 8);
    push(n);
    wb(`RX_LEVEL_OFFSET, 1'b0, 32'h0, q);
    `CHK(q, 32'(n))
    wr(`FIFO_EN_OFFSET, 32'h1);
    settle(2);
    `CHK(rtsN, 1'b0)
    @(posedge sys_clk) statIn.autoFlow <= 1'b1;
    push(10 - n);
    settle(2);
    `CHK(rtsN, 1'b1)
    // alternative trigger: ten entries is not yet two slots from full
    @(posedge sys_clk) statIn.altTrigger <= 1'b1;
    settle(2);
    `CHK(rtsN, 1'b0)
    push(4);
    settle(2);
    `CHK(rtsN, 1'b1)
    @(posedge sys_clk) statIn.altTrigger <= 1'b0;
    $display("test flow done");
    // fifo resets clear themselves after three cycles
    fork countHigh(1, c); wr(`SOFT_RESET_OFFSET, 32'h2); join
    `CHK(c, 3)
    wb(`RX_LEVEL_OFFSET, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    settle(2);
    `CHK(rtsN, 1'b0)
    fork countHigh(0, c); wr(`SOFT_RESET_OFFSET, 32'h4); join
    `CHK(c, 3)
    wb(`SOFT_RESET_OFFSET, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    $display("test fifo reset done");
    // loopback, break and infrared
    @(posedge sys_clk) statIn.loopback <= 1'b1;
    wr(`BREAK_MIRROR_OFFSET, 32'h1);
    settle(2);
    `CHK({rtsN, loopRts}, 2'b11)
    `CHK({serOut, loopRxData}, 2'b10)
    @(posedge sys_clk) statIn <= '{loopback: 1'b0, irActive: 1'b1, autoFlow: 1'b1, default: 1'b0};
    settle(2);
    `CHK(serOut, 1'b0)
    `CHK(breakBit, 1'b1)
    // one low pulse every sixteen cycles: exactly one in the counting window
    countHigh(3, c);
    `CHK(c, 1)
    wr(`BREAK_MIRROR_OFFSET, 32'h0);
    $display("test break done");
    // dma signalling mode selects the transmit request source
    @(posedge sys_clk) statIn.txEmpty <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(`DMA_MODE_OFFSET, 32'(m));
      settle(2);
      `CHK(dmaTxReqN, 1'(m))
      `CHK({dmaRxReqN, dmaTxSingleN, dmaRxSingleN}, 3'b111)
    end
    $display("test dma done");
    // disabling fifos flushes the receive fifo for three cycles
    fork countHigh(1, c); wr(`FIFO_EN_OFFSET, 32'h0); join
    `CHK(c, 3)
    `CHK(fifoEnBit, 1'b0)
    $display("test fifo disable done");
    // whole reset clears the rts and dma mode shared bits
    wr(`RTS_MIRROR_OFFSET, 32'h1);
    fork countHigh(2, c); wr(`SOFT_RESET_OFFSET, 32'h1); join
    `CHK(c, 4)
    wb(`RTS_MIRROR_OFFSET, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK({rtsBit, dmaModeBit}, 2'b00)
    $display("test whole reset done");
    finishTest();
  end
endmodule : uart_shadow_register_bank_bench
